// file: scs_clock_select.sv
// System clock source selection, PLL lock wait and glitch-free switch
module scs_clock_select
    import scs_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = PLL_LOCK_CYCLES
)
(
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic [2:0] main_osc_mode_bits_i,
    input  wire logic       clock_switch_enable_fuse_i,
    input  wire logic       secondary_osc_enable_i,
    input  wire logic       select_wr_i,
    input  wire logic       select_wdata_i,
    input  wire logic       oscillator_in_pin_i,
    input  wire logic       secondary_oscillator_i,
    input  wire logic       port_a_bit_six_io_i,
    input  wire logic       port_a_bit_six_oe_i,
    output logic            clock_source_select_o,
    output logic            oscillator_out_pin_o,
    output logic            oscillator_out_oe_o,
    output logic            port_a_bit_six_io_o,
    output logic            feedback_enable_o,
    output logic            pll_enable_o,
    output logic            pll_lock_done_o,
    output logic            run_enable_o,
    output logic            sys_clk_src_o
);
    // =================================================================
    // Pin synchronisers
    logic [1:0] main_sync_ff;
    logic [1:0] sec_sync_ff;
    logic       main_prev_ff;
    logic       sec_prev_ff;
    logic       main_rise;
    logic       sec_rise;

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            main_sync_ff <= 2'h0;
            sec_sync_ff  <= 2'h0;
            main_prev_ff <= 1'h0;
            sec_prev_ff  <= 1'h0;
        end
        else
        begin
            main_sync_ff <= {main_sync_ff[0], oscillator_in_pin_i};
            sec_sync_ff  <= {sec_sync_ff[0], secondary_oscillator_i};
            main_prev_ff <= main_sync_ff[1];
            sec_prev_ff  <= sec_sync_ff[1];
        end
    end

    assign main_rise = main_sync_ff[1] & ~main_prev_ff;
    assign sec_rise  = sec_sync_ff[1] & ~sec_prev_ff;

    // =================================================================
    // Mode decode
    scs_mode_t mode;
    scs_pin_t  pins;
    logic      is_pll;
    logic      pa_read;
    logic      div_ff;
    logic [1:0] div_cnt_ff;

    assign mode = scs_mode_t'(main_osc_mode_bits_i);
    assign is_pll = (mode == SCS_HSPL);
    // Port bit readback follows the port logic only while it owns the pin
    assign pa_read = (mode == SCS_RESISTOR_CAPACITOR_IO_MODE || mode == SCS_EXTERNAL_CLOCK_IO_MODE)
                   & port_a_bit_six_io_i;

    always_comb
    begin
        pins = '0;
        pins.feedback_on = 1'h1;
        unique case (mode)
            SCS_RC, SCS_EC:
            begin
                pins.out_level  = div_ff;
                pins.out_enable = 1'h1;
            end
            SCS_RESISTOR_CAPACITOR_IO_MODE, SCS_EXTERNAL_CLOCK_IO_MODE:
            begin
                pins.out_level  = port_a_bit_six_io_i;
                pins.out_enable = port_a_bit_six_oe_i;
            end
            default:
            begin
                pins.out_level  = 1'h0;
                pins.out_enable = 1'h0;
            end
        endcase
        if (mode == SCS_EC || mode == SCS_EXTERNAL_CLOCK_IO_MODE || mode == SCS_RC || mode == SCS_RESISTOR_CAPACITOR_IO_MODE)
            pins.feedback_on = (mode == SCS_RC || mode == SCS_RESISTOR_CAPACITOR_IO_MODE);
        pins.pll_on = is_pll;
    end

    // Divide by four of the oscillator: toggle every other rising edge
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            div_cnt_ff <= 2'h0;
            div_ff     <= 1'h0;
        end
        else if (main_rise)
        begin
            div_cnt_ff <= div_cnt_ff + 2'h1;
            if (div_cnt_ff[0])
                div_ff <= ~div_ff;
        end
    end

    // =================================================================
    // PLL lock timer; non-PLL modes need no start-up wait
    localparam int unsigned LW = $clog2(LOCK_CYCLES + 1);
    logic [LW-1:0] lock_cnt_ff;
    logic          lock_done_ff;

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            lock_cnt_ff  <= '0;
            lock_done_ff <= 1'h0;
        end
        else if (!is_pll)
        begin
            lock_cnt_ff  <= '0;
            lock_done_ff <= 1'h1;
        end
        else if (!lock_done_ff)
        begin
            lock_cnt_ff <= lock_cnt_ff + LW'(1);
            if (lock_cnt_ff == LW'(LOCK_CYCLES - 1))
                lock_done_ff <= 1'h1;
        end
    end

    // =================================================================
    // Source select bit and glitch-free switch
    logic       select_ff;
    logic       active_src_ff;
    logic       switching_ff;
    logic [3:0] edge_cnt_ff;
    logic       allowed;
    logic       new_rise;

    assign allowed = (clock_switch_enable_fuse_i == FUSE_SWITCH_ON)
                   & secondary_osc_enable_i;
    assign new_rise = select_ff ? sec_rise : main_rise;

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            select_ff <= 1'h0;
        else if (!allowed)
            select_ff <= 1'h0;
        else if (select_wr_i)
            select_ff <= select_wdata_i;
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            active_src_ff <= 1'h0;
            switching_ff  <= 1'h0;
            edge_cnt_ff   <= 4'h0;
        end
        else if (select_ff != active_src_ff && !switching_ff)
        begin
            switching_ff <= 1'h1;
            edge_cnt_ff  <= 4'h0;
        end
        else if (switching_ff && new_rise)
        begin
            edge_cnt_ff <= edge_cnt_ff + 4'h1;
            if (edge_cnt_ff == 4'(SYNC_EDGES - 1))
            begin
                switching_ff  <= 1'h0;
                active_src_ff <= select_ff;
            end
        end
    end

    // =================================================================
    // Registered outputs
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            clock_source_select_o <= 1'h0;
            oscillator_out_pin_o  <= 1'h0;
            oscillator_out_oe_o   <= 1'h0;
            port_a_bit_six_io_o   <= 1'h0;
            feedback_enable_o     <= 1'h0;
            pll_enable_o          <= 1'h0;
            pll_lock_done_o       <= 1'h0;
            run_enable_o          <= 1'h0;
            sys_clk_src_o         <= 1'h0;
        end
        else
        begin
            clock_source_select_o <= select_ff;
            oscillator_out_pin_o  <= pins.out_level;
            oscillator_out_oe_o   <= pins.out_enable;
            port_a_bit_six_io_o   <= pa_read;
            feedback_enable_o     <= pins.feedback_on;
            pll_enable_o          <= pins.pll_on;
            pll_lock_done_o       <= lock_done_ff;
            // Execution frozen during lock wait and switch synchronisation
            run_enable_o          <= lock_done_ff & ~switching_ff
                                   & (select_ff == active_src_ff);
            sys_clk_src_o         <= active_src_ff;
        end
    end

    // =================================================================
    // Checks
    a_select_forced_low: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !allowed |=> !select_ff)
        else $error("select set while switching not allowed");
    a_lock_gates_run: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !lock_done_ff |=> !run_enable_o)
        else $error("run enabled before lock done");
    a_nonpll_no_wait: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !is_pll |=> lock_done_ff)
        else $error("start-up wait outside PLL mode");
    a_switch_freezes: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        switching_ff |=> !run_enable_o)
        else $error("run during switch");
    a_pll_only_hs: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        pll_enable_o |-> $past(is_pll))
        else $error("PLL on outside PLL mode");
    a_ext_no_feedback: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (mode == SCS_EC || mode == SCS_EXTERNAL_CLOCK_IO_MODE) |=> !feedback_enable_o)
        else $error("feedback on in external clock mode");
    a_io_mode_pin: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (mode == SCS_RESISTOR_CAPACITOR_IO_MODE || mode == SCS_EXTERNAL_CLOCK_IO_MODE) |=> oscillator_out_oe_o == $past(port_a_bit_six_oe_i))
        else $error("out pin not given to port bit");
    a_div_out_drive: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (mode == SCS_RC || mode == SCS_EC) |=> oscillator_out_oe_o)
        else $error("divided clock not driven");
    a_div_pin_level: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (mode == SCS_RC || mode == SCS_EC) |=> oscillator_out_pin_o == $past(div_ff))
        else $error("divided clock level wrong");
    a_io_pin_level: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (mode == SCS_RESISTOR_CAPACITOR_IO_MODE || mode == SCS_EXTERNAL_CLOCK_IO_MODE) |=> oscillator_out_pin_o == $past(port_a_bit_six_io_i))
        else $error("out pin level not from port bit");
    a_port_bit_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !(mode == SCS_RESISTOR_CAPACITOR_IO_MODE || mode == SCS_EXTERNAL_CLOCK_IO_MODE) |=> !port_a_bit_six_io_o)
        else $error("port bit readback outside I/O mode");
    a_crystal_feedback: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !(mode == SCS_EC || mode == SCS_EXTERNAL_CLOCK_IO_MODE) |=> feedback_enable_o)
        else $error("feedback off outside external clock mode");
    a_pll_mult: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        is_pll |=> pll_enable_o)
        else $error("PLL off in PLL mode");
    a_pll_lock_wait: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !lock_done_ff |=> !pll_lock_done_o)
        else $error("lock reported before timer expiry");
    a_lock_count: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $rose(lock_done_ff) && is_pll |-> $past(lock_cnt_ff) == LW'(LOCK_CYCLES - 1))
        else $error("lock released at wrong count");

    // =================================================================
    // Independent cycle count since reset, for the lock length check
    logic [LW-1:0] lock_seen_ff;

    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            lock_seen_ff <= '0;
        else if (lock_seen_ff != LW'(LOCK_CYCLES))
            lock_seen_ff <= lock_seen_ff + LW'(1);
    end

    a_lock_not_early: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        is_pll && lock_done_ff |-> lock_seen_ff == LW'(LOCK_CYCLES))
        else $error("lock done before full wait");

    // =================================================================
    // Switch and reset checks
    sequence s_switch_start;
        select_ff != active_src_ff && !switching_ff;
    endsequence
    sequence s_switch_done;
        switching_ff ##1 !switching_ff;
    endsequence

    a_switch_begins: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_switch_start |=> switching_ff)
        else $error("source change without freeze");
    a_src_after_eight: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        $changed(active_src_ff) |-> $past(switching_ff) && $past(edge_cnt_ff) == 4'(SYNC_EDGES - 1))
        else $error("source changed before eight edges");
    a_run_after_switch: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        s_switch_done ##0 (select_ff == active_src_ff) |=> run_enable_o == $past(lock_done_ff))
        else $error("run not resumed after switch");
    a_select_readback: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        1'h1 |=> clock_source_select_o == $past(select_ff))
        else $error("select readback wrong");
    a_src_output: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        1'h1 |=> sys_clk_src_o == $past(active_src_ff))
        else $error("active source output wrong");
    a_reset_clears: assert property (@(posedge sys_clk_i)
        reset_i |=> !select_ff && !clock_source_select_o && !sys_clk_src_o)
        else $error("select not cleared by reset");
    a_fuse_blocks: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (clock_switch_enable_fuse_i != FUSE_SWITCH_ON) |=> !select_ff)
        else $error("select set with switching fused off");
endmodule

// file: scs_pkg.sv
// Package of constants and types for the system clock source select block
// =====================================================================
package scs_pkg;
    localparam int unsigned SYS_CLK_MHZ     = 100;
    localparam int unsigned PLL_LOCK_US     = 2000;
    localparam int unsigned PLL_LOCK_CYCLES = PLL_LOCK_US * SYS_CLK_MHZ;
    localparam int unsigned SYNC_EDGES      = 8;
    localparam int unsigned OUT_DIV         = 4;
    localparam int unsigned PORT_A_IO_BIT   = 6;
    localparam logic        FUSE_SWITCH_ON  = 1'h0;

    typedef enum logic [2:0]
    {
        SCS_LP   = 3'h0,
        SCS_XT   = 3'h1,
        SCS_HS   = 3'h2,
        SCS_RC   = 3'h3,
        SCS_EC   = 3'h4,
        SCS_EXTERNAL_CLOCK_IO_MODE = 3'h5,
        SCS_HSPL = 3'h6,
        SCS_RESISTOR_CAPACITOR_IO_MODE = 3'h7
    } scs_mode_t;

    typedef struct packed
    {
        logic out_level;
        logic out_enable;
        logic feedback_on;
        logic pll_on;
    } scs_pin_t;
endpackage

// file: scs_osc_model.sv
// Free-running external oscillators facing the clock select block
module scs_osc_model
#(
    parameter int MAIN_HALF = 41,
    parameter int SEC_HALF  = 87
)
(
    output logic main_osc_o,
    output logic sec_osc_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================================
    // Sources
    // Both run free; periods are unrelated to the system clock on purpose
    initial main_osc_o = 1'h0;
    initial sec_osc_o  = 1'h0;
    always #(MAIN_HALF) main_osc_o = ~main_osc_o;
    always #(SEC_HALF) sec_osc_o = ~sec_osc_o;
endmodule

// file: tb_top.sv
// Self-checking testbench for the system clock source select block
module tb_top;
    import scs_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned LOCK = 20;
    logic       sys_clk_i  = 1'h0;
    logic       reset_i    = 1'h1;
    logic [2:0] mode       = 3'h4;
    logic       fuse       = 1'h1;
    logic       sec_en     = 1'h0;
    logic       sel_wr     = 1'h0;
    logic       sel_data   = 1'h0;
    logic       pa_io      = 1'h0;
    logic       pa_oe      = 1'h0;
    wire        main_osc, sec_osc, sel_o, out_pin, out_oe, fb, pll, lock, run, src, pa_rd;
    int         n_mismatch = 0;
    int         tests_run  = 0;
    int         n_main     = 0;
    int         n_sec      = 0;
    int         s;
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge main_osc) n_main++;
    always @(posedge sec_osc) n_sec++;
    scs_osc_model osc (.main_osc_o(main_osc), .sec_osc_o(sec_osc));
    scs_clock_select #(.LOCK_CYCLES(LOCK)) dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .main_osc_mode_bits_i(mode),
        .clock_switch_enable_fuse_i(fuse), .secondary_osc_enable_i(sec_en),
        .select_wr_i(sel_wr), .select_wdata_i(sel_data), .oscillator_in_pin_i(main_osc),
        .secondary_oscillator_i(sec_osc), .port_a_bit_six_io_i(pa_io),
        .port_a_bit_six_oe_i(pa_oe), .clock_source_select_o(sel_o),
        .oscillator_out_pin_o(out_pin), .oscillator_out_oe_o(out_oe),
        .port_a_bit_six_io_o(pa_rd), .feedback_enable_o(fb), .pll_enable_o(pll),
        .pll_lock_done_o(lock), .run_enable_o(run), .sys_clk_src_o(src));
    // ==========================================
    // Tasks
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    task automatic smp(input int n);
        cyc(n);
        @(negedge sys_clk_i);
    endtask
    // Mode is static, so it only changes under reset
    task automatic do_reset(input logic [2:0] m);
        @(posedge sys_clk_i);
        reset_i <= 1'h1;
        mode    <= m;
        cyc(8);
        reset_i <= 1'h0;
    endtask
    task automatic write_sel(input logic v);
        @(posedge sys_clk_i);
        sel_wr   <= 1'h1;
        sel_data <= v;
        @(posedge sys_clk_i);
        sel_wr   <= 1'h0;
        smp(3);
    endtask
    task automatic wait_src(input logic v);
        int k;
        for (k = 0; k < 600 && src !== v; k++)
            @(negedge sys_clk_i);
    endtask
    task automatic wait_rise;
        int   k;
        logic prev;
        prev = out_pin;
        for (k = 0; k < 200; k++)
        begin
            @(negedge sys_clk_i);
            if (out_pin === 1'h1 && prev === 1'h0)
                break;
            prev = out_pin;
        end
    endtask
    task automatic div_check;
        wait_rise();
        s = n_main;
        wait_rise();
        check(8'(n_main - s), 8'h04);
        check(8'(out_oe), 8'h01);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ==========================================
    // Tests
    initial
    begin
        cyc(8);
        reset_i <= 1'h0;
        smp(0);
        check(8'({sel_o, src}), 8'h00);
        smp(3);
        check(8'({run, fb, pll}), 8'h04);
        div_check();
        for (int m = 0; m < 8; m++)
        begin
            do_reset(3'(m));
            smp(4);
            check(8'(fb), (m == 4 || m == 5) ? 8'h00 : 8'h01);
            check(8'(pll), (m == 6) ? 8'h01 : 8'h00);
        end
        do_reset(3'h3);
        div_check();
        for (int m = 5; m < 8; m += 2)
        begin
            do_reset(3'(m));
            @(posedge sys_clk_i);
            pa_io <= 1'h1;
            pa_oe <= 1'h1;
            smp(2);
            check(8'({out_oe, out_pin}), 8'h03);
            check(8'(pa_rd), 8'h01);
            @(posedge sys_clk_i);
            pa_io <= 1'h0;
            smp(2);
            check(8'({out_oe, out_pin}), 8'h02);
            check(8'(pa_rd), 8'h00);
            @(posedge sys_clk_i);
            pa_oe <= 1'h0;
        end
        do_reset(3'h6);
        smp(5);
        check(8'({lock, run}), 8'h00);
        smp(LOCK + 10);
        check(8'({lock, run}), 8'h03);
        do_reset(3'h4);
        smp(4);
        write_sel(1'h1);
        check(8'(sel_o), 8'h00);
        @(posedge sys_clk_i);
        fuse <= 1'h0;
        write_sel(1'h1);
        check(8'(sel_o), 8'h00);
        @(posedge sys_clk_i);
        sec_en <= 1'h1;
        s = n_sec;
        write_sel(1'h1);
        check(8'({sel_o, run}), 8'h02);
        wait_src(1'h1);
        check(8'(src), 8'h01);
        check(8'(n_sec - s >= 8 && n_sec - s <= 10), 8'h01);
        smp(3);
        check(8'(run), 8'h01);
        s = n_main;
        write_sel(1'h0);
        wait_src(1'h0);
        check(8'(n_main - s >= 8 && n_main - s <= 10), 8'h01);
        write_sel(1'h1);
        @(posedge sys_clk_i);
        sec_en <= 1'h0;
        smp(3);
        check(8'(sel_o), 8'h00);
        @(posedge sys_clk_i);
        sec_en <= 1'h1;
        write_sel(1'h1);
        wait_src(1'h1);
        do_reset(3'h4);
        smp(1);
        check(8'({sel_o, src}), 8'h00);
        complete_run();
    end
    // Whole run needs under a thousand cycles
    initial
    begin
        cyc(20000);
        n_mismatch++;
        complete_run();
    end
endmodule
